// File: hdl/osc_pkg.sv
// Function
// - Decode fuses into source and PLL factor
// - Primary mode alone sets output pin role
// - Primary input pin never becomes general I/O
// - Erased fuse bits read as one
// - Active source loads at POR, updates after switch
// - Pending choice loads at POR and brown-out
// - Divide ratio field at bits 8:7
// - PLL settled flag at bit 5, read-only
// - Clock fail flag bit 3, hardware set
// - Bit 1 enables slow crystal oscillator
// - Bit 0 starts switch, self-clears on completion
// - Four-bit trim shifts fast RC frequency
// - Low byte unlocks after 0x46 then 0x57
// - One low byte write allowed after unlock
// - High byte unlocks after 0x78 then 0x9A
// - One high byte write allowed after unlock
// - Monitor fuses gate switching and fail monitor
// Package of constants and types for the oscillator select and switch control.
// Assumes an APB4 master with byte strobes and a 25 MHz pclk.
package osc_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TRIM = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam int ACT_LSB = 12;
  localparam int PEND_LSB = 9;
  localparam int DIV_LSB = 7;
  localparam int LOCK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int SLOW_BIT = 1;
  localparam int SWREQ_BIT = 0;
  localparam logic [7:0] KEY_LO_1 = 8'h46;
  localparam logic [7:0] KEY_LO_2 = 8'h57;
  localparam logic [7:0] KEY_HI_1 = 8'h78;
  localparam logic [7:0] KEY_HI_2 = 8'h9A;
  localparam logic [1:0] FUSE_SRC_ERASED = 2'h3;
  localparam logic [3:0] FUSE_MODE_ERASED = 4'hF;
  localparam logic [1:0] FUSE_MON_ERASED = 2'h3;
  localparam logic [1:0] DIV_RESET = 2'h0;
  localparam logic [3:0] TRIM_RESET = 4'h0;
  localparam logic [1:0] LOAD_AT = 2'h2;
  localparam logic [5:0] DIV_M1_1 = 6'h00;
  localparam logic [5:0] DIV_M1_4 = 6'h03;
  localparam logic [5:0] DIV_M1_16 = 6'h0F;
  localparam logic [5:0] DIV_M1_64 = 6'h3F;

  typedef enum logic [1:0] {SRC_WATCH, SRC_FAST_RC, SRC_SLOW_RC, SRC_PRIMARY} osc_src_e;
  typedef enum logic [1:0] {PIN_IO, PIN_CLOCK_OUT, PIN_CRYSTAL} osc_pin_e;
  typedef enum logic [1:0] {LK_IDLE, LK_KEY1, LK_OPEN} osc_lock_e;

  typedef struct packed {
    osc_src_e source;
    osc_pin_e out_pin;
    logic [4:0] pll_mult;
    logic external_primary;
  } osc_mode_s;

  typedef struct packed {
    logic switch_enable;
    logic monitor_enable;
  } osc_mon_s;

  function automatic logic [5:0] div_last(input logic [1:0] ratio);
    case (ratio)
      2'h0: div_last = DIV_M1_1;
      2'h1: div_last = DIV_M1_4;
      2'h2: div_last = DIV_M1_16;
      default: div_last = DIV_M1_64;
    endcase
  endfunction
endpackage

// File: hdl/osc_ctrl.sv
// Oscillator source selection, run-time switch control and unlock-protected control register.
// Assumes fuse and status inputs arrive asynchronously and the clock mux reports completion.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module osc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] fuse_power_up_source,
  input wire logic [3:0] fuse_primary_mode,
  input wire logic [1:0] fuse_switch_monitor,
  input wire logic brown_out_pulse,
  input wire logic pll_lock_raw,
  input wire logic clock_fail_raw,
  input wire logic switch_done_raw,
  output logic [1:0] switch_target,
  output logic switch_go,
  output logic [1:0] active_source,
  output osc_pkg::osc_mode_s boot_mode,
  output logic fail_monitor_en,
  output logic slow_crystal_on,
  output logic [3:0] rc_trim_value,
  output logic sysclk_en,
  output logic primary_in_io_en
);
  // Two-stage synchronisers; erased-fuse reset value keeps unprogrammed parts on the default mode
  logic [1:0] src_s1_q, src_s2_q;
  logic [3:0] mode_s1_q, mode_s2_q;
  logic [1:0] mon_s1_q, mon_s2_q;
  logic [3:0] ev_s1_q, ev_s2_q;
  logic bor_prev_q, done_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_s1_q <= osc_pkg::FUSE_SRC_ERASED;
      src_s2_q <= osc_pkg::FUSE_SRC_ERASED;
      mode_s1_q <= osc_pkg::FUSE_MODE_ERASED;
      mode_s2_q <= osc_pkg::FUSE_MODE_ERASED;
      mon_s1_q <= osc_pkg::FUSE_MON_ERASED;
      mon_s2_q <= osc_pkg::FUSE_MON_ERASED;
      ev_s1_q <= 4'h0;
      ev_s2_q <= 4'h0;
      bor_prev_q <= 1'b0;
      done_prev_q <= 1'b0;
    end else begin
      src_s1_q <= fuse_power_up_source;
      src_s2_q <= src_s1_q;
      mode_s1_q <= fuse_primary_mode;
      mode_s2_q <= mode_s1_q;
      mon_s1_q <= fuse_switch_monitor;
      mon_s2_q <= mon_s1_q;
      ev_s1_q <= {switch_done_raw, clock_fail_raw, pll_lock_raw, brown_out_pulse};
      ev_s2_q <= ev_s1_q;
      bor_prev_q <= ev_s2_q[0];
      done_prev_q <= ev_s2_q[3];
    end
  end

  logic bor_rise, lock_sync, fail_sync, done_rise;
  assign bor_rise = ev_s2_q[0] & ~bor_prev_q;
  assign lock_sync = ev_s2_q[1];
  assign fail_sync = ev_s2_q[2];
  assign done_rise = ev_s2_q[3] & ~done_prev_q;

  // Fuse decode: oscillator group plus primary mode table
  osc_pkg::osc_mode_s mode_dec;
  osc_pkg::osc_mon_s mon_dec;
  always_comb begin
    mode_dec.source = osc_pkg::osc_src_e'(src_s2_q);
    mode_dec.pll_mult = 5'h00;
    mode_dec.external_primary = 1'b0;
    mode_dec.out_pin = osc_pkg::PIN_CRYSTAL;
    // Pin role follows the primary mode only, whatever group is selected
    unique case (mode_s2_q)
      4'hF: begin
        mode_dec.out_pin = osc_pkg::PIN_IO;
        mode_dec.pll_mult = 5'h10;
      end
      4'hE: begin
        mode_dec.out_pin = osc_pkg::PIN_IO;
        mode_dec.pll_mult = 5'h08;
      end
      4'hD: begin
        mode_dec.out_pin = osc_pkg::PIN_IO;
        mode_dec.pll_mult = 5'h04;
      end
      4'hC, 4'hA, 4'h8: mode_dec.out_pin = osc_pkg::PIN_IO;
      4'hB, 4'h9: mode_dec.out_pin = osc_pkg::PIN_CLOCK_OUT;
      4'h7: mode_dec.pll_mult = 5'h10;
      4'h6: mode_dec.pll_mult = 5'h08;
      4'h5: mode_dec.pll_mult = 5'h04;
      4'h4, 4'h3, 4'h2, 4'h1, 4'h0: mode_dec.pll_mult = 5'h00;
    endcase
    if (src_s2_q != 2'h3) begin
      mode_dec.pll_mult = 5'h00;
    end else begin
      mode_dec.external_primary = (mode_dec.pll_mult == 5'h00);
    end
    mon_dec.switch_enable = ~mon_s2_q[1];
    mon_dec.monitor_enable = (mon_s2_q == 2'h0);
  end

  // APB access qualifiers; one setup cycle, the access phase always completes at once
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic xfer, wr, hit_ctrl, lane_lo, lane_hi, hit_trim;
  assign xfer = psel & penable & pready_q;
  assign wr = xfer & pwrite;
  assign hit_ctrl = (paddr == osc_pkg::OFS_CTRL);
  assign lane_lo = wr & hit_ctrl & pstrb[0];
  assign lane_hi = wr & hit_ctrl & pstrb[1];
  // Trim sits in its own register with no key, so tuning never disturbs the switch logic
  assign hit_trim = wr & (paddr == osc_pkg::OFS_TRIM) & pstrb[0];

  // Any transfer advances the unlock sequence, so nothing may sit between the keys
  function automatic osc_pkg::osc_lock_e lock_next(
    input osc_pkg::osc_lock_e cur,
    input logic hit,
    input logic [7:0] data,
    input logic [7:0] key1,
    input logic [7:0] key2
  );
    if (cur == osc_pkg::LK_OPEN) begin
      lock_next = osc_pkg::LK_IDLE;
    end else if (hit && cur == osc_pkg::LK_KEY1 && data == key2) begin
      lock_next = osc_pkg::LK_OPEN;
    end else if (hit && data == key1) begin
      lock_next = osc_pkg::LK_KEY1;
    end else begin
      lock_next = osc_pkg::LK_IDLE;
    end
  endfunction

  // Control state
  osc_pkg::osc_lock_e lock_lo_q, lock_lo_d, lock_hi_q, lock_hi_d;
  logic [1:0] act_q, act_d, pend_q, pend_d, div_q, div_d, load_cnt_q, load_cnt_d;
  logic fail_q, fail_d, slow_q, slow_d, swreq_q, swreq_d;
  logic [3:0] trim_q, trim_d;
  osc_pkg::osc_mode_s boot_q, boot_d;
  osc_pkg::osc_mon_s mon_q, mon_d;
  logic wen_lo, wen_hi;
  logic [15:0] wd;
  logic pin_io_q;

  always_comb begin
    wd = pwdata[15:0];
    lock_lo_d = lock_lo_q;
    lock_hi_d = lock_hi_q;
    // Only completed transfers move the key trackers; idle cycles between keys are harmless
    if (xfer) begin
      lock_lo_d = lock_next(lock_lo_q, lane_lo, wd[7:0], osc_pkg::KEY_LO_1,
        osc_pkg::KEY_LO_2);
      lock_hi_d = lock_next(lock_hi_q, lane_hi, wd[15:8], osc_pkg::KEY_HI_1,
        osc_pkg::KEY_HI_2);
    end
    // A byte lands only in the transfer right after its key pair
    wen_lo = lane_lo && (lock_lo_q == osc_pkg::LK_OPEN);
    wen_hi = lane_hi && (lock_hi_q == osc_pkg::LK_OPEN);

    load_cnt_d = load_cnt_q;
    act_d = act_q;
    pend_d = pend_q;
    div_d = div_q;
    fail_d = fail_q;
    slow_d = slow_q;
    swreq_d = swreq_q;
    trim_d = trim_q;
    boot_d = boot_q;
    mon_d = mon_q;

    // Fuses are taken once the synchronisers hold them, not from the reset branch
    if (load_cnt_q != 2'h3) begin
      load_cnt_d = load_cnt_q + 2'h1;
    end
    if (load_cnt_q == osc_pkg::LOAD_AT) begin
      act_d = src_s2_q;
      pend_d = src_s2_q;
      boot_d = mode_dec;
      mon_d = mon_dec;
    end

    if (wen_lo) begin
      div_d[0] = wd[osc_pkg::DIV_LSB];
      fail_d = wd[osc_pkg::FAIL_BIT];
      slow_d = wd[osc_pkg::SLOW_BIT];
      // With switching fused off the request bit stays clear
      if (mon_q.switch_enable) begin
        swreq_d = wd[osc_pkg::SWREQ_BIT];
      end
    end
    if (wen_hi) begin
      div_d[1] = wd[osc_pkg::DIV_LSB + 1];
      pend_d = wd[osc_pkg::PEND_LSB +: 2];
    end

    if (bor_rise) begin
      pend_d = src_s2_q;
    end

    // Completion moves the status to the target and drops the request
    if (done_rise && swreq_q) begin
      act_d = pend_q;
      swreq_d = 1'b0;
    end

    // Hardware set beats a software clear in the same cycle
    if (fail_sync && mon_q.monitor_enable) begin
      fail_d = 1'b1;
    end

    if (hit_trim) begin
      trim_d = pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_lo_q <= osc_pkg::LK_IDLE;
      lock_hi_q <= osc_pkg::LK_IDLE;
      act_q <= osc_pkg::FUSE_SRC_ERASED;
      pend_q <= osc_pkg::FUSE_SRC_ERASED;
      div_q <= osc_pkg::DIV_RESET;
      load_cnt_q <= 2'h0;
      fail_q <= 1'b0;
      slow_q <= 1'b0;
      swreq_q <= 1'b0;
      trim_q <= osc_pkg::TRIM_RESET;
      boot_q <= '0;
      mon_q <= '0;
      pin_io_q <= 1'b0;
    end else begin
      lock_lo_q <= lock_lo_d;
      lock_hi_q <= lock_hi_d;
      act_q <= act_d;
      pend_q <= pend_d;
      div_q <= div_d;
      load_cnt_q <= load_cnt_d;
      fail_q <= fail_d;
      slow_q <= slow_d;
      swreq_q <= swreq_d;
      trim_q <= trim_d;
      boot_q <= boot_d;
      mon_q <= mon_d;
      pin_io_q <= 1'b0;
    end
  end

  // Read path: data is registered in the setup cycle and stands through the access phase
  logic [31:0] ctrl_word;
  logic setup, mapped;

  always_comb begin
    ctrl_word = 32'h0;
    ctrl_word[osc_pkg::ACT_LSB +: 2] = act_q;
    ctrl_word[osc_pkg::PEND_LSB +: 2] = pend_q;
    ctrl_word[osc_pkg::DIV_LSB +: 2] = div_q;
    ctrl_word[osc_pkg::LOCK_BIT] = lock_sync;
    ctrl_word[osc_pkg::FAIL_BIT] = fail_q;
    ctrl_word[osc_pkg::SLOW_BIT] = slow_q;
    ctrl_word[osc_pkg::SWREQ_BIT] = swreq_q;
    setup = psel & ~penable;
    mapped = (paddr == osc_pkg::OFS_CTRL) || (paddr == osc_pkg::OFS_TRIM) ||
      (paddr == osc_pkg::OFS_MODE);
    pready_d = setup;
    pslverr_d = setup & ~mapped;
    prdata_d = 32'h0;
    if (setup && !pwrite) begin
      if (paddr == osc_pkg::OFS_CTRL) begin
        prdata_d = ctrl_word;
      end else if (paddr == osc_pkg::OFS_TRIM) begin
        prdata_d = {28'h0, trim_q};
      end else if (paddr == osc_pkg::OFS_MODE) begin
        prdata_d = {20'h0, mon_q, boot_q};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // System clock divider: a one-cycle enable per divided period
  logic [5:0] div_cnt_q, div_cnt_d;
  logic sys_q, sys_d;

  always_comb begin
    div_cnt_d = div_cnt_q + 6'h01;
    sys_d = 1'b0;
    // Greater-or-equal lets a shorter ratio take over at once after a change
    if (div_cnt_q >= osc_pkg::div_last(div_q)) begin
      div_cnt_d = 6'h00;
      sys_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 6'h00;
      sys_q <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      sys_q <= sys_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign switch_target = pend_q;
  assign switch_go = swreq_q;
  assign active_source = act_q;
  assign boot_mode = boot_q;
  assign fail_monitor_en = mon_q.monitor_enable;
  assign slow_crystal_on = slow_q;
  assign rc_trim_value = trim_q;
  assign sysclk_en = sys_q;
  assign primary_in_io_en = pin_io_q;
endmodule // osc_ctrl

// File: tb/osc_ctrl_checker.sv
// Port assertions for osc_ctrl, bound to it below.
// Assumes the fuse inputs stay steady while out of reset.
`timescale 1ns/1ps
module osc_ctrl_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [3:0] pstrb,
  input wire logic [3:0] fuse_primary_mode,
  input wire logic [1:0] fuse_switch_monitor,
  input wire logic brown_out_pulse,
  input wire logic switch_done_raw,
  input wire logic [1:0] switch_target,
  input wire logic [1:0] active_source,
  input wire osc_pkg::osc_mode_s boot_mode,
  input wire logic fail_monitor_en,
  input wire logic slow_crystal_on,
  input wire logic [3:0] rc_trim_value,
  input wire logic primary_in_io_en
);
  logic wr;
  assign wr = psel && penable && pwrite && pready;
  // Fuses are loaded a few cycles after reset; the monitor and erased-mode decode checks wait until then
  logic [2:0] since_q;
  logic settled;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_q <= 3'h0;
    end else if (since_q != 3'h7) begin
      since_q <= since_q + 3'h1;
    end
  end
  assign settled = (since_q == 3'h7);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Raw completion may pass a short synchroniser first
  sequence s_done_seen;
    $past(switch_done_raw) || $past(switch_done_raw, 2) || $past(switch_done_raw, 3);
  endsequence
  a_pin_never_io: assert property (!primary_in_io_en)
    else $error("primary input pin offered as io");
  a_monitor_decode: assert property (settled |-> fail_monitor_en == (fuse_switch_monitor == 2'h0))
    else $error("monitor enable decode wrong");
  a_erased_default: assert property (settled && fuse_primary_mode == 4'hF |->
    boot_mode.out_pin == osc_pkg::PIN_IO)
    else $error("erased mode pin role wrong");
  a_clock_out_role: assert property (boot_mode.out_pin == osc_pkg::PIN_CLOCK_OUT |->
    fuse_primary_mode inside {4'hB, 4'h9})
    else $error("clock output role without clock mode");
  a_active_hold: assert property (settled && $changed(active_source) |-> s_done_seen)
    else $error("active source moved without completion");
  a_active_target: assert property (settled && $changed(active_source) |->
    active_source == $past(switch_target))
    else $error("active source not the target");
  a_slow_by_write: assert property ($changed(slow_crystal_on) |->
    $past(wr && pstrb[0]) || $past(brown_out_pulse))
    else $error("slow crystal enable moved without write");
  a_trim_by_write: assert property ($changed(rc_trim_value) |-> $past(wr))
    else $error("trim moved without write");
endmodule // osc_ctrl_checker
bind osc_ctrl osc_ctrl_checker i_osc_ctrl_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pstrb(pstrb),
  .fuse_primary_mode(fuse_primary_mode), .fuse_switch_monitor(fuse_switch_monitor),
  .brown_out_pulse(brown_out_pulse), .switch_done_raw(switch_done_raw),
  .switch_target(switch_target), .active_source(active_source), .boot_mode(boot_mode),
  .fail_monitor_en(fail_monitor_en), .slow_crystal_on(slow_crystal_on),
  .rc_trim_value(rc_trim_value), .primary_in_io_en(primary_in_io_en));

// File: tb/osc_ctrl_tb.sv
// Self-checking bench for osc_ctrl through APB byte writes.
// Assumes byte writes use their own lane and raw status inputs settle within 8 clocks.
`timescale 1ns/1ps
module osc_ctrl_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0, trim;
  logic pready, pslverr, bo = 1'b0, lock = 1'b0, fail = 1'b0, done = 1'b0;
  logic go, mon, slow, sys, io, err;
  int npulse = 0;
  logic [1:0] tgt, act;
  osc_pkg::osc_mode_s bm;
  int n_errors = 0, compares = 0;
  always #20 pclk = ~pclk;
  osc_ctrl i_osc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fuse_power_up_source(2'h1),
    .fuse_primary_mode(4'hF), .fuse_switch_monitor(2'h0), .brown_out_pulse(bo),
    .pll_lock_raw(lock), .clock_fail_raw(fail), .switch_done_raw(done),
    .switch_target(tgt), .switch_go(go), .active_source(act), .boot_mode(bm),
    .fail_monitor_en(mon), .slow_crystal_on(slow), .rc_trim_value(trim),
    .sysclk_en(sys), .primary_in_io_en(io));
  // Leaves psel up so unlock writes run back to back
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int n;
    n = 0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) n_errors++;
    rd = prdata;
    err = pslverr;
  endtask
  task automatic idle(input int c);
    {psel, penable} <= 2'b00;
    repeat (c) @(posedge pclk);
  endtask
  task automatic wlo(input logic [7:0] b);
    xfer(1'b1, osc_pkg::OFS_CTRL, {24'h0, b}, 4'h1);
  endtask
  task automatic whi(input logic [7:0] b);
    xfer(1'b1, osc_pkg::OFS_CTRL, {16'h0, b, 8'h00}, 4'h2);
  endtask
  task automatic rctl();
    xfer(1'b0, osc_pkg::OFS_CTRL, 32'h0, 4'h0);
    idle(1);
  endtask
  function automatic logic [31:0] f(input int l, input int w);
    f = (rd >> l) & ((32'h1 << w) - 32'h1);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rctl();
    chk("act", 32'h1, f(osc_pkg::ACT_LSB, 2));
    chk("pend", 32'h1, f(osc_pkg::PEND_LSB, 2));
    chk("low", 32'h0, f(0, 6));
    chk("mon", 32'h1, {31'h0, mon});
    chk("pin", 32'h0, {30'h0, bm.out_pin} ^ {30'h0, osc_pkg::PIN_IO});
    wlo(8'h02);
    wlo(8'h57);
    wlo(8'h46);
    wlo(8'h02);
    rctl();
    chk("slow0", 32'h0, f(osc_pkg::SLOW_BIT, 1));
    wlo(8'h46);
    wlo(8'h57);
    wlo(8'h02);
    wlo(8'h00);
    rctl();
    chk("slow1", 32'h1, f(osc_pkg::SLOW_BIT, 1));
    chk("slowp", 32'h1, {31'h0, slow});
    whi(8'h78);
    whi(8'h9A);
    whi(8'h37);
    whi(8'h00);
    rctl();
    chk("pendw", 32'h3, f(osc_pkg::PEND_LSB, 2));
    chk("div", 32'h2, f(osc_pkg::DIV_LSB, 2));
    chk("actro", 32'h1, f(osc_pkg::ACT_LSB, 2));
    repeat (64) begin
      @(posedge pclk);
      npulse += int'(sys);
    end
    chk("sysdiv", 32'h4, npulse);
    wlo(8'h46);
    wlo(8'h57);
    wlo(8'h03);
    idle(4);
    chk("tgt", 32'h3, {30'h0, tgt});
    chk("go", 32'h1, {31'h0, go});
    done <= 1'b1;
    repeat (3) @(posedge pclk);
    done <= 1'b0;
    repeat (8) @(posedge pclk);
    rctl();
    chk("actsw", 32'h3, f(osc_pkg::ACT_LSB, 2));
    chk("req", 32'h0, f(osc_pkg::SWREQ_BIT, 1));
    chk("go0", 32'h0, {31'h0, go});
    {lock, fail, bo} <= 3'b111;
    @(posedge pclk);
    {fail, bo} <= 2'b00;
    repeat (8) @(posedge pclk);
    rctl();
    chk("lock", 32'h1, f(osc_pkg::LOCK_BIT, 1));
    chk("fail", 32'h1, f(osc_pkg::FAIL_BIT, 1));
    chk("pendbo", 32'h1, f(osc_pkg::PEND_LSB, 2));
    xfer(1'b1, osc_pkg::OFS_TRIM, 32'h0000000A, 4'hF);
    idle(2);
    chk("trim", 32'hA, {28'h0, trim});
    xfer(1'b0, 8'h40, 32'h0, 4'h0);
    idle(1);
    chk("slverr", 32'h1, {31'h0, err});
    tally_and_finish();
  end
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
endmodule // osc_ctrl_tb
